/* File: core/flp_pkg.sv */
package flp_pkg;

    // register word addresses on the plain register port
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CTRL_KEY = 8'h04;
    localparam logic [7:0] ADDR_PROG_KEY = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_OPTION = 8'h10;
    localparam logic [7:0] ADDR_SECTOR = 8'h14;
    localparam logic [7:0] ADDR_OPT_WRITE = 8'h18;

    localparam logic [31:0] CTRL_KEY_FIRST = 32'h89AB_CDEF;
    localparam logic [31:0] CTRL_KEY_SECOND = 32'h0203_0405;
    localparam logic [31:0] PROG_KEY_FIRST = 32'h8C9D_AEBF;
    localparam logic [31:0] PROG_KEY_SECOND = 32'h1314_1516;

    // control register fields
    localparam int CTRL_LOCK_BIT = 0;
    localparam int PROG_LOCK_BIT = 1;
    localparam int MASS_ERASE_BIT = 2;

    // status register fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_EOP_BIT = 1;
    localparam int ST_HVOFF_BIT = 2;
    localparam int ST_RDERR_BIT = 3;
    localparam int ST_WRPERR_BIT = 4;

    // option word fields
    localparam int OPT_LEVEL_LSB = 0;
    localparam int OPT_GUARD_MODE_BIT = 8;

    localparam logic [7:0] LEVEL0_CODE = 8'hAA;
    localparam logic [7:0] LEVEL1_DEFAULT = 8'h00;
    localparam logic [15:0] SECTORS_OPEN = 16'hFFFF;
    localparam int SECTOR_COUNT = 16;

    // program memory window: 16 sectors of 4 KB
    localparam logic [31:0] PROG_BASE = 32'h1000_0000;
    localparam logic [31:0] PROG_LIMIT = 32'h1001_0000;
    localparam int SECTOR_LSB = 12;

    // programming time
    localparam int PROG_TIME_NS = 2000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam logic [7:0] PROG_CYCLES_M1 = 8'(PROG_CYCLES - 1);

    typedef enum logic [2:0] {
        FLP_KEY_IDLE = 3'b001,
        FLP_KEY_HALF = 3'b010,
        FLP_KEY_DONE = 3'b100
    } flp_key_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } flp_reg_req_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic err;
    } flp_reg_rsp_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
        logic fetch;
    } flp_mem_req_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic rvalid;
        logic stall;
    } flp_mem_rsp_t;

    typedef struct packed {
        logic ctrlLock;
        logic progLock;
        flp_key_t ctrlKey;
        flp_key_t progKey;
        logic busy;
        logic eop;
        logic rdErr;
        logic wrpErr;
        logic [7:0] level;
        logic guardMode;
        logic [15:0] sectorOpen;
        logic [7:0] progCnt;
        logic pendValid;
        logic [31:0] pendAddr;
        logic [31:0] pendData;
        logic loaded;
        logic massErase;
        logic nvmWr;
        logic [31:0] nvmAddr;
        logic [31:0] nvmData;
        logic nvmRd;
        flp_reg_rsp_t regRsp;
        flp_mem_rsp_t memRsp;
    } flp_state_t;

endpackage

/* File: core/flp_lock_ctrl.sv */
// Operation
// R1: control register locked after reset
// R2: two control keys in order unlock control
// R3: bad control key sequence gives fault
// R4: reads between keys neither fault nor break
// R5: unlocked control register accepts bit writes
// R6: setting control lock relocks until keys
// R7: program keys clear program lock when unlocked
// R8: program keys while control locked: ignored
// R9: bad program key sequence gives fault
// R10: program relocks by software or control lock
// R11: busy during write; new write stalls, pends
// R12: protected read while busy sets read error
// R13: end flag set at finish, cleared by one
// R14: high-voltage-off flag mirrors memory array
// R15: boot loads 8-bit level; 0xAA is open
// R16: other level codes mean level one
// R17: level one with debug blocks program memory
// R18: mass erase sets level zero, guard off
// R19: guard mode: zero bit protects 4 KB sector
// R20: sector n starts at base plus n*4KB
// R21: guarded data read/write flag errors; fetch ok
// R22: guard mode only ever adds protection
// R23: blocked read returns zero data
// R24: key fault reported as bus error response
module flp_lock_ctrl
    import flp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire flp_reg_req_t regReq,
    output flp_reg_rsp_t regRsp,
    input wire flp_mem_req_t memReq,
    output flp_mem_rsp_t memRsp,
    input wire logic debugAttached,
    input wire logic hvOffIn,
    input wire logic [31:0] optionWord,
    input wire logic optionValid,
    input wire logic [31:0] nvmRdata,
    output logic nvmWr,
    output logic nvmRd,
    output logic [31:0] nvmAddr,
    output logic [31:0] nvmData,
    output logic hvOff,
    output logic massEraseReq
);

    flp_state_t st;
    flp_state_t next_st;
    logic hvOffQ;

    ////////////////////////////////////////////////////////////////////////
    // sector decode
    logic inProg;
    logic [3:0] sectorIdx;
    logic [SECTOR_COUNT-1:0] sectorHit;
    logic sectorGuarded;
    logic levelBlocks;

    assign inProg = (memReq.addr >= PROG_BASE) && (memReq.addr < PROG_LIMIT);
    assign sectorIdx = memReq.addr[SECTOR_LSB +: 4];

    genvar gi;
    generate
        for (gi = 0; gi < SECTOR_COUNT; gi++) begin : g_sector
            // R19 R20
            assign sectorHit[gi] = inProg && (sectorIdx == 4'(gi)) && !st.sectorOpen[gi];
        end
    endgenerate

    assign sectorGuarded = st.guardMode && (|sectorHit); // R19
    assign levelBlocks = inProg && (st.level != LEVEL0_CODE) && debugAttached; // R16 R17

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic wrOther;
        logic [31:0] newOpt;
        logic setEop;
        logic setRdErr;
        logic setWrpErr;
        wrOther = 1'b0;
        newOpt = 32'h0000_0000;
        setEop = 1'b0;
        setRdErr = 1'b0;
        setWrpErr = 1'b0;
        next_st = st;
        next_st.regRsp = '0;
        next_st.memRsp.rvalid = 1'b0;
        next_st.memRsp.rdata = 32'h0000_0000;
        next_st.nvmWr = 1'b0;
        next_st.nvmRd = 1'b0;
        next_st.massErase = 1'b0;

        // option load at boot
        if (!st.loaded && optionValid) begin
            next_st.loaded = 1'b1;
            next_st.level = optionWord[OPT_LEVEL_LSB +: 8]; // R15
            next_st.guardMode = optionWord[OPT_GUARD_MODE_BIT];
            next_st.sectorOpen = optionWord[31:16];
        end

        if (regReq.wr) begin
            wrOther = (regReq.addr != ADDR_CTRL_KEY) && (regReq.addr != ADDR_PROG_KEY);
            // control key sequence
            if (regReq.addr == ADDR_CTRL_KEY) begin
                unique case (st.ctrlKey)
                    FLP_KEY_IDLE: begin
                        if (regReq.wdata == CTRL_KEY_FIRST) begin
                            next_st.ctrlKey = FLP_KEY_HALF; // R2
                        end else begin
                            next_st.regRsp.err = 1'b1; // R3 R24
                        end
                    end
                    FLP_KEY_HALF: begin
                        if (regReq.wdata == CTRL_KEY_SECOND) begin
                            next_st.ctrlKey = FLP_KEY_DONE;
                            next_st.ctrlLock = 1'b0; // R2
                        end else begin
                            next_st.ctrlKey = FLP_KEY_IDLE;
                            next_st.regRsp.err = 1'b1; // R3 R24
                        end
                    end
                    FLP_KEY_DONE: begin
                        next_st.regRsp.err = 1'b1; // R3
                    end
                    default: next_st.ctrlKey = FLP_KEY_IDLE;
                endcase
            end
            // program key sequence; silently ignored while control locked
            if (regReq.addr == ADDR_PROG_KEY && !st.ctrlLock) begin // R8
                unique case (st.progKey)
                    FLP_KEY_IDLE: begin
                        if (regReq.wdata == PROG_KEY_FIRST) begin
                            next_st.progKey = FLP_KEY_HALF; // R7
                        end else begin
                            next_st.regRsp.err = 1'b1; // R9 R24
                        end
                    end
                    FLP_KEY_HALF: begin
                        if (regReq.wdata == PROG_KEY_SECOND) begin
                            next_st.progKey = FLP_KEY_DONE;
                            next_st.progLock = 1'b0; // R7
                        end else begin
                            next_st.progKey = FLP_KEY_IDLE;
                            next_st.regRsp.err = 1'b1; // R9 R24
                        end
                    end
                    FLP_KEY_DONE: begin
                        next_st.regRsp.err = 1'b1; // R9
                    end
                    default: next_st.progKey = FLP_KEY_IDLE;
                endcase
            end
            // other register written mid-sequence
            if (wrOther && (st.ctrlKey == FLP_KEY_HALF || st.progKey == FLP_KEY_HALF)) begin
                next_st.regRsp.err = 1'b1; // R3 R9
                if (st.ctrlKey == FLP_KEY_HALF) begin
                    next_st.ctrlKey = FLP_KEY_IDLE;
                end
                if (st.progKey == FLP_KEY_HALF) begin
                    next_st.progKey = FLP_KEY_IDLE;
                end
            end else if (regReq.addr == ADDR_CTRL && !st.ctrlLock) begin
                // R5
                if (regReq.wdata[PROG_LOCK_BIT]) begin
                    next_st.progLock = 1'b1; // R10
                    next_st.progKey = FLP_KEY_IDLE;
                end
                if (regReq.wdata[CTRL_LOCK_BIT]) begin
                    next_st.ctrlLock = 1'b1; // R6
                    next_st.ctrlKey = FLP_KEY_IDLE;
                    next_st.progLock = 1'b1; // R10
                    next_st.progKey = FLP_KEY_IDLE;
                end
                if (regReq.wdata[MASS_ERASE_BIT] && !st.progLock && !st.busy) begin
                    next_st.massErase = 1'b1;
                    next_st.level = LEVEL0_CODE; // R18
                    next_st.guardMode = 1'b0; // R18
                    next_st.sectorOpen = SECTORS_OPEN;
                    next_st.busy = 1'b1;
                    next_st.progCnt = PROG_CYCLES_M1;
                end
            end else if (regReq.addr == ADDR_OPT_WRITE && !st.ctrlLock) begin
                newOpt = regReq.wdata;
                if (st.guardMode) begin
                    next_st.sectorOpen = st.sectorOpen & newOpt[31:16]; // R22
                end else begin
                    next_st.guardMode = newOpt[OPT_GUARD_MODE_BIT];
                    next_st.sectorOpen = newOpt[31:16];
                end
                next_st.busy = 1'b1;
                next_st.progCnt = PROG_CYCLES_M1;
            end
        end

        // register reads; they never touch the key sequences
        if (regReq.rd) begin
            unique case (regReq.addr) // R4
                ADDR_CTRL: begin
                    next_st.regRsp.rdata[CTRL_LOCK_BIT] = st.ctrlLock;
                    next_st.regRsp.rdata[PROG_LOCK_BIT] = st.progLock;
                end
                ADDR_STATUS: begin
                    next_st.regRsp.rdata[ST_BUSY_BIT] = st.busy;
                    next_st.regRsp.rdata[ST_EOP_BIT] = st.eop;
                    next_st.regRsp.rdata[ST_HVOFF_BIT] = hvOffQ; // R14
                    next_st.regRsp.rdata[ST_RDERR_BIT] = st.rdErr;
                    next_st.regRsp.rdata[ST_WRPERR_BIT] = st.wrpErr;
                end
                ADDR_OPTION: begin
                    next_st.regRsp.rdata[OPT_LEVEL_LSB +: 8] = st.level;
                    next_st.regRsp.rdata[OPT_GUARD_MODE_BIT] = st.guardMode;
                    next_st.regRsp.rdata[31:16] = st.sectorOpen;
                end
                default: next_st.regRsp.rdata = 32'h0000_0000;
            endcase
        end

        // programming timer
        if (st.busy) begin
            if (st.progCnt == 8'h00) begin
                if (st.pendValid) begin
                    next_st.pendValid = 1'b0; // R11
                    next_st.nvmWr = 1'b1;
                    next_st.nvmAddr = st.pendAddr;
                    next_st.nvmData = st.pendData;
                    next_st.progCnt = PROG_CYCLES_M1;
                end else begin
                    next_st.busy = 1'b0;
                    next_st.eop = 1'b1; // R13
                    setEop = 1'b1;
                end
            end else begin
                next_st.progCnt = st.progCnt - 8'h01;
            end
        end

        // memory requests
        next_st.memRsp.stall = st.pendValid;
        if (memReq.wr) begin
            if (st.progLock || sectorGuarded || levelBlocks) begin
                next_st.wrpErr = 1'b1; // R21
                setWrpErr = 1'b1;
            end else if (st.busy) begin
                next_st.pendValid = 1'b1; // R11
                next_st.pendAddr = memReq.addr;
                next_st.pendData = memReq.wdata;
                next_st.memRsp.stall = 1'b1;
            end else begin
                next_st.busy = 1'b1; // R11
                next_st.progCnt = PROG_CYCLES_M1;
                next_st.nvmWr = 1'b1;
                next_st.nvmAddr = memReq.addr;
                next_st.nvmData = memReq.wdata;
            end
        end
        if (memReq.rd) begin
            if (levelBlocks || (sectorGuarded && !memReq.fetch)) begin
                next_st.rdErr = 1'b1; // R12 R21
                setRdErr = 1'b1;
                next_st.memRsp.rvalid = 1'b1;
                next_st.memRsp.rdata = 32'h0000_0000; // R23
            end else begin
                next_st.nvmRd = 1'b1;
                next_st.nvmAddr = memReq.addr;
            end
        end
        if (st.nvmRd) begin
            next_st.memRsp.rvalid = 1'b1;
            next_st.memRsp.rdata = nvmRdata;
        end

        // write-one-to-clear; a set in the same cycle wins
        if (regReq.wr && regReq.addr == ADDR_STATUS) begin
            if (regReq.wdata[ST_EOP_BIT] && !setEop) begin
                next_st.eop = 1'b0; // R13
            end
            if (regReq.wdata[ST_RDERR_BIT] && !setRdErr) begin
                next_st.rdErr = 1'b0;
            end
            if (regReq.wdata[ST_WRPERR_BIT] && !setWrpErr) begin
                next_st.wrpErr = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.ctrlLock <= 1'b1; // R1
            st.progLock <= 1'b1; // R10
            st.ctrlKey <= FLP_KEY_IDLE;
            st.progKey <= FLP_KEY_IDLE;
            st.level <= LEVEL1_DEFAULT; // R16
            st.sectorOpen <= SECTORS_OPEN;
            hvOffQ <= 1'b1;
        end else begin
            st <= next_st;
            hvOffQ <= hvOffIn; // R14
        end
    end

    assign regRsp = st.regRsp;
    assign memRsp = st.memRsp;
    assign nvmWr = st.nvmWr;
    assign nvmRd = st.nvmRd;
    assign nvmAddr = st.nvmAddr;
    assign nvmData = st.nvmData;
    assign hvOff = hvOffQ;
    assign massEraseReq = st.massErase;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_ctrl_keys;
        regReq.wr && regReq.addr == ADDR_CTRL_KEY && regReq.wdata == CTRL_KEY_FIRST
            && st.ctrlKey == FLP_KEY_IDLE
            ##1 regReq.wr && regReq.addr == ADDR_CTRL_KEY && regReq.wdata == CTRL_KEY_SECOND;
    endsequence

    property p_reset_locked;
        @(posedge clk_sys) $rose(rst_n) |-> st.ctrlLock && st.progLock;
    endproperty
    a_reset_locked: assert property (p_reset_locked) else $error("locks not set at reset"); // R1

    property p_ctrl_unlock;
        @(posedge clk_sys) disable iff (!rst_n) s_ctrl_keys |=> !st.ctrlLock;
    endproperty
    a_ctrl_unlock: assert property (p_ctrl_unlock) else $error("control keys did not unlock"); // R2

    property p_bad_first;
        @(posedge clk_sys) disable iff (!rst_n)
            regReq.wr && regReq.addr == ADDR_CTRL_KEY && st.ctrlKey == FLP_KEY_IDLE
            && regReq.wdata != CTRL_KEY_FIRST |=> regRsp.err && st.ctrlLock;
    endproperty
    a_bad_first: assert property (p_bad_first) else $error("bad first key not faulted"); // R3

    property p_locked_ctrl;
        @(posedge clk_sys) disable iff (!rst_n)
            st.ctrlLock && !(regReq.wr && regReq.addr == ADDR_CTRL_KEY)
            |=> st.ctrlLock && st.progLock;
    endproperty
    a_locked_ctrl: assert property (p_locked_ctrl) else $error("locked control changed"); // R6

    property p_prog_locked_silent;
        @(posedge clk_sys) disable iff (!rst_n)
            st.ctrlLock && regReq.wr && regReq.addr == ADDR_PROG_KEY
            |=> !regRsp.err && st.progLock;
    endproperty
    a_prog_locked_silent: assert property (p_prog_locked_silent) else $error("prog key err"); // R8

    property p_relock_chain;
        @(posedge clk_sys) disable iff (!rst_n) $rose(st.ctrlLock) |-> st.progLock;
    endproperty
    a_relock_chain: assert property (p_relock_chain) else $error("prog not relocked"); // R10

    property p_busy_span;
        @(posedge clk_sys) disable iff (!rst_n) $rose(st.busy) |-> st.busy[*8];
    endproperty
    a_busy_span: assert property (p_busy_span) else $error("busy too short"); // R11

    property p_eop_on_end;
        @(posedge clk_sys) disable iff (!rst_n) $fell(st.busy) |-> st.eop;
    endproperty
    a_eop_on_end: assert property (p_eop_on_end) else $error("eop not set"); // R13

    property p_blocked_zero;
        @(posedge clk_sys) disable iff (!rst_n)
            memReq.rd && !memReq.fetch && sectorGuarded |=> memRsp.rvalid
            && memRsp.rdata == 32'h0000_0000 && st.rdErr;
    endproperty
    a_blocked_zero: assert property (p_blocked_zero) else $error("blocked read leaked"); // R23

    property p_guard_only_adds;
        @(posedge clk_sys) disable iff (!rst_n)
            st.guardMode && !st.massErase |=> st.massErase
            || (st.sectorOpen & ~$past(st.sectorOpen)) == 16'h0000;
    endproperty
    a_guard_only_adds: assert property (p_guard_only_adds) else $error("guard reduced"); // R22

endmodule

/* File: dv/flp_nvm_model.sv */
module flp_nvm_model (
    input wire logic clk_sys,
    input wire logic nvmWr,
    input wire logic nvmRd,
    input wire logic [31:0] nvmAddr,
    input wire logic [31:0] nvmData,
    output logic [31:0] nvmRdata,
    output logic hvOffIn
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] mem [logic [31:0]];
    logic [7:0] hvCnt = 8'h00;

    initial begin
        nvmRdata = 32'h0000_0000;
        hvOffIn = 1'b1;
    end

    // regulators stay on for a while after each programming pulse
    always @(posedge clk_sys) begin
        if (nvmWr) begin
            mem[nvmAddr] = nvmData;
            hvCnt <= 8'h96;
        end else if (hvCnt != 8'h00) begin
            hvCnt <= hvCnt - 8'h01;
        end
        hvOffIn <= !(nvmWr || hvCnt > 8'h01);
    end

    // read data settle inside the read cycle, before the edge at which the block takes them
    always @(negedge clk_sys) begin
        // idle data lines toggle so a stale value is never mistaken for an answer
        nvmRdata <= nvmRd ? (mem.exists(nvmAddr) ? mem[nvmAddr] : ~nvmAddr) : ~nvmRdata;
    end
endmodule

/* File: dv/flash_lock_protect_ctrl_test.sv */
module flash_lock_protect_ctrl_test;
    import flp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    flp_reg_req_t regReq = '0;
    flp_reg_rsp_t regRsp;
    flp_mem_req_t memReq = '0;
    flp_mem_rsp_t memRsp;
    logic debugAttached = 1'b0;
    logic hvOffIn;
    logic [31:0] optionWord = 32'hFFFE_01AA;
    logic [31:0] nvmRdata;
    logic [31:0] nvmAddr;
    logic [31:0] nvmData;
    logic nvmWr, nvmRd, hvOff, massEraseReq;
    logic rdPrev = 1'b0;
    logic wrPrev = 1'b0;
    logic hvPrev = 1'b1;
    logic [32:0] regQ[$];
    logic [31:0] memQ[$];
    logic [32:0] note;
    int nFail = 0;
    int nChecks = 0;
    int nErase = 0;
    integer seed;
    logic [31:0] d1, d2, a1, a2, aF, bad;
    logic [7:0] lvl;

    always #5 clk_sys = ~clk_sys;

    flp_lock_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .regReq(regReq), .regRsp(regRsp),
        .memReq(memReq), .memRsp(memRsp), .debugAttached(debugAttached), .hvOffIn(hvOffIn),
        .optionWord(optionWord), .optionValid(1'b1), .nvmRdata(nvmRdata), .nvmWr(nvmWr),
        .nvmRd(nvmRd), .nvmAddr(nvmAddr), .nvmData(nvmData), .hvOff(hvOff),
        .massEraseReq(massEraseReq));

    flp_nvm_model nvm (.clk_sys(clk_sys), .nvmWr(nvmWr), .nvmRd(nvmRd), .nvmAddr(nvmAddr),
        .nvmData(nvmData), .nvmRdata(nvmRdata), .hvOffIn(hvOffIn));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        nChecks++;
        if (seen !== exp) begin
            nFail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (nFail == 0 && nChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        @(posedge clk_sys);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        memReq <= '0;
        regQ.push_back({e, 32'h0000_0000});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regReq <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        memReq <= '0;
        regQ.push_back({1'b0, d});
    endtask

    task automatic mop(input logic [31:0] a, input logic [31:0] d, input logic [2:0] k);
        @(posedge clk_sys);
        memReq <= '{addr: a, wdata: d, wr: k[2], rd: k[1], fetch: k[0]};
        regReq <= '0;
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            regReq <= '0;
            memReq <= '0;
        end
    endtask

    task automatic unlock_ctrl;
        wr(ADDR_CTRL_KEY, CTRL_KEY_FIRST, 1'b0);
        wr(ADDR_CTRL_KEY, CTRL_KEY_SECOND, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        if (rst_n) begin
            if (rdPrev || wrPrev) begin
                if (regQ.size() == 0) begin
                    chk(33'h0_0000_0000, 33'h1_FFFF_FFFF);
                end else begin
                    note = regQ.pop_front();
                    chk({regRsp.err, rdPrev ? regRsp.rdata : 32'h0000_0000},
                        {note[32], rdPrev ? note[31:0] : 32'h0000_0000});
                end
            end
            if (memRsp.rvalid) begin
                chk({1'b0, memRsp.rdata}, {memQ.size() == 0, memQ.pop_front()});
            end
            chk({32'h0000_0000, hvOff}, {32'h0000_0000, hvPrev});
            if (massEraseReq) nErase++;
        end
        rdPrev <= regReq.rd;
        wrPrev <= regReq.wr;
        hvPrev <= hvOffIn;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        nFail++;
        tally_and_finish();
    end

    initial begin
        seed = 82893;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(ADDR_CTRL, 32'h0000_0003);
        rd(ADDR_STATUS, 32'h0000_0004);
        rd(ADDR_OPTION, 32'hFFFE_01AA);
        wr(ADDR_CTRL, 32'h0000_0000, 1'b0);
        rd(ADDR_CTRL, 32'h0000_0003);
        wr(ADDR_PROG_KEY, PROG_KEY_FIRST, 1'b0);
        wr(ADDR_PROG_KEY, PROG_KEY_SECOND, 1'b0);
        rd(ADDR_CTRL, 32'h0000_0003);
        bad = CTRL_KEY_FIRST ^ (32'($random(seed)) | 32'h0000_0001);
        wr(ADDR_CTRL_KEY, bad, 1'b1);
        wr(ADDR_CTRL_KEY, CTRL_KEY_FIRST, 1'b0);
        wr(ADDR_STATUS, 32'h0000_0000, 1'b1);
        wr(ADDR_CTRL_KEY, CTRL_KEY_FIRST, 1'b0);
        wr(ADDR_CTRL_KEY, CTRL_KEY_SECOND ^ 32'h0000_0100, 1'b1);
        rd(ADDR_CTRL, 32'h0000_0003);
        wr(ADDR_CTRL_KEY, CTRL_KEY_FIRST, 1'b0);
        rd(ADDR_CTRL, 32'h0000_0003);
        wr(ADDR_CTRL_KEY, CTRL_KEY_SECOND, 1'b0);
        rd(ADDR_CTRL, 32'h0000_0002);
        wr(ADDR_CTRL_KEY, CTRL_KEY_FIRST, 1'b1);
        wr(ADDR_CTRL, 32'h0000_0001, 1'b0);
        rd(ADDR_CTRL, 32'h0000_0003);
        unlock_ctrl();
        rd(ADDR_CTRL, 32'h0000_0002);
        wr(ADDR_PROG_KEY, PROG_KEY_FIRST, 1'b0);
        wr(ADDR_PROG_KEY, PROG_KEY_SECOND ^ 32'h0001_0000, 1'b1);
        wr(ADDR_PROG_KEY, PROG_KEY_FIRST, 1'b0);
        rd(ADDR_CTRL, 32'h0000_0002);
        wr(ADDR_PROG_KEY, PROG_KEY_SECOND, 1'b0);
        wr(ADDR_PROG_KEY, bad, 1'b1);
        rd(ADDR_CTRL, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_0002, 1'b0);
        rd(ADDR_CTRL, 32'h0000_0002);
        wr(ADDR_PROG_KEY, PROG_KEY_FIRST, 1'b0);
        wr(ADDR_PROG_KEY, PROG_KEY_SECOND, 1'b0);
        rd(ADDR_CTRL, 32'h0000_0000);
        d1 = $random(seed);
        d2 = $random(seed);
        a1 = PROG_BASE + 32'h0000_5000 + (32'($random(seed)) & 32'h0000_0FF8);
        a2 = a1 + 32'h0000_0004;
        aF = PROG_BASE + (32'($random(seed)) & 32'h0000_0FFC);
        mop(a1, d1, 3'b100);
        idle(5);
        rd(ADDR_STATUS, 32'h0000_0001);
        mop(a2, d2, 3'b100);
        idle(2);
        #1 chk({32'h0000_0000, memRsp.stall}, 33'h0_0000_0001);
        memQ.push_back(32'h0000_0000);
        mop(aF ^ 32'h0000_0008, 32'h0000_0000, 3'b010);
        memQ.push_back(~aF);
        mop(aF, 32'h0000_0000, 3'b011);
        idle(500);
        mop(aF, d1, 3'b100);
        idle(3);
        rd(ADDR_STATUS, 32'h0000_001E);
        wr(ADDR_STATUS, 32'h0000_001A, 1'b0);
        rd(ADDR_STATUS, 32'h0000_0004);
        wr(ADDR_OPT_WRITE, 32'h7FFF_0000, 1'b0);
        rd(ADDR_OPTION, 32'h7FFE_01AA);
        memQ.push_back(d1);
        mop(a1, 32'h0000_0000, 3'b010);
        idle(3);
        memQ.push_back(d2);
        mop(a2, 32'h0000_0000, 3'b010);
        idle(5);
        lvl = 8'($random(seed));
        if (lvl === LEVEL0_CODE) lvl = 8'h55;
        rst_n <= 1'b0;
        optionWord <= {16'hFFFF, 8'h00, lvl};
        debugAttached <= 1'b1;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(ADDR_CTRL, 32'h0000_0003);
        memQ.push_back(32'h0000_0000);
        mop(PROG_BASE + 32'h0000_0300, 32'h0000_0000, 3'b010);
        idle(4);
        unlock_ctrl();
        wr(ADDR_PROG_KEY, PROG_KEY_FIRST, 1'b0);
        wr(ADDR_PROG_KEY, PROG_KEY_SECOND, 1'b0);
        wr(ADDR_CTRL, 32'h0000_0004, 1'b0);
        idle(20);
        rd(ADDR_OPTION, 32'hFFFF_00AA);
        idle(3);
        chk(33'(nErase), 33'h0_0000_0001);
        chk(33'(regQ.size() + memQ.size()), 33'h0_0000_0000);
        tally_and_finish();
    end
endmodule
